// ---- design/rbq_pkg.sv ----
package rbq_pkg;

    // ------------------------------------------------------------------
    // datapath widths
    // ------------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int COEF_W = 32;
    localparam int PROD_W = DATA_W + COEF_W;
    localparam int SUM_W = PROD_W + 3;
    localparam int FRAC_SHIFT = 31;
    localparam int CH_W = 2;
    localparam int SEC_W = 4;
    localparam int STAGE_W = 2;

    // ------------------------------------------------------------------
    // bank geometry
    // ------------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int MAX_SEC_PER_CH = 3;
    localparam int NUM_SEC = 12;
    localparam int COEFS_PER_SEC = 5;
    localparam int BYTES_PER_COEF = 4;
    localparam int REGS_PER_SEC = 20;
    localparam int SEC_PER_PAGE = 6;
    localparam int FIFO_DEPTH = 8;

    // ------------------------------------------------------------------
    // coefficient order inside a section block
    // ------------------------------------------------------------------
    localparam int IDX_N0 = 0;
    localparam int IDX_N1 = 1;
    localparam int IDX_N2 = 2;
    localparam int IDX_D1 = 3;
    localparam int IDX_D2 = 4;

    // ------------------------------------------------------------------
    // paged coefficient space
    // ------------------------------------------------------------------
    localparam logic [7:0] PAGE_LO = 8'h08;
    localparam logic [7:0] PAGE_HI = 8'h09;
    localparam logic [6:0] REG_FIRST = 7'h08;
    localparam logic [6:0] REG_LAST = 7'h7f;

    // ------------------------------------------------------------------
    // reset values and limits
    // ------------------------------------------------------------------
    localparam logic [COEF_W-1:0] COEF_UNITY = 32'h7fffffff;
    localparam logic [COEF_W-1:0] COEF_ZERO = 32'h00000000;
    localparam logic [DATA_W-1:0] DATA_MAX = 32'h7fffffff;
    localparam logic [DATA_W-1:0] DATA_MIN = 32'h80000000;
    localparam logic [1:0] ALLOC_BYPASS = 2'b00;
    localparam logic [1:0] ALLOC_ONE = 2'b01;
    localparam logic [1:0] ALLOC_TWO = 2'b10;
    localparam logic [1:0] ALLOC_THREE = 2'b11;
    localparam logic [CH_W-1:0] ALT_BANK_OFFSET = 2'h2;

    // ------------------------------------------------------------------
    // sequencer states, gray along idle -> run -> push
    // ------------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_PUSH = 2'b11
    } rbq_state_type;

endpackage : rbq_pkg

// ---- design/rbq_fifo.sv ----
module rbq_fifo #(
    parameter int WIDTH = 34,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // ------------------------------------------------------------------
    // structure
    // ------------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("rbq_fifo depth must be a power of two of at least two");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;

    wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
        && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    wire empty = (wr_ptr_reg == rd_ptr_reg);
    wire push = in_valid && !full;
    wire pop = out_valid && out_ready;

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];

    // ------------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end
        else if (ce)
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
    end

    // storage has no reset: only written slots are ever read
    always_ff @(posedge clk)
    begin
        if (ce && push)
            mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end

endmodule : rbq_fifo

// ---- design/rbq_filter_bank.sv ----
// Functional notes
// - Twelve programmable sections exist and a channel never runs more than three of them.
// - Each section computes y = (N0 x + 2 N1 x1 + N2 x2 + 2 D1 y1 + D2 y2) / 2^31.
// - After reset every section holds all-pass unity-gain coefficients.
// - In two-channel use a channel switches between two banks under a switch bit.
// - An allocation value of zero bypasses filtering on every channel.
// - Allocation one gives sections 1-4 to channels 1-4 and leaves 5-12 unused.
// - Allocation two, the reset value, gives sections 1-8 two per channel.
// - Allocation three gives sections 1-12 three per channel.
// - A two-bit allocation field chooses the section count applied per output channel.
// - Sections 1-6 live in 20-register blocks from register 8 of page 8, 7-12 in page 9.
module rbq_filter_bank #(
    parameter int NUM_SECTIONS = rbq_pkg::NUM_SEC,
    parameter int NUM_CHANNELS = rbq_pkg::NUM_CH,
    parameter int FIFO_WORDS = rbq_pkg::FIFO_DEPTH
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [1:0] SECTION_ALLOCATION_SEL,
    input wire logic TWO_CH_MODE,
    input wire logic BANK_SWITCH,
    input wire logic COEF_WR_EN,
    input wire logic [7:0] COEF_PAGE,
    input wire logic [6:0] COEF_INDEX,
    input wire logic [7:0] COEF_BYTE,
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [rbq_pkg::CH_W-1:0] IN_CHANNEL,
    input wire logic [rbq_pkg::DATA_W-1:0] IN_DATA,
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [rbq_pkg::CH_W-1:0] OUT_CHANNEL,
    output logic [rbq_pkg::DATA_W-1:0] OUT_DATA,
    output logic ACTIVE_BANK
);
    import rbq_pkg::*;

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (NUM_CHANNELS != NUM_CH || NUM_SECTIONS != NUM_CH * MAX_SEC_PER_CH)
    begin : g_bad_geometry
        $error("rbq_filter_bank serves exactly four channels of three sections");
    end

    if (FIFO_WORDS < 2)
    begin : g_bad_fifo
        $error("rbq_filter_bank output fifo needs at least two words");
    end

    if (COEFS_PER_SEC * BYTES_PER_COEF != REGS_PER_SEC)
    begin : g_bad_block
        $error("rbq_filter_bank section block size does not match its words");
    end

    if (int'(REG_FIRST) + SEC_PER_PAGE * REGS_PER_SEC - 1 != int'(REG_LAST))
    begin : g_bad_page
        $error("rbq_filter_bank sections do not fill the page window");
    end

    if (2 * int'(ALT_BANK_OFFSET) != NUM_CH)
    begin : g_bad_split
        $error("rbq_filter_bank alternate banks must split the channels in half");
    end

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------
    // section number from page and register, out-of-range writes give a miss
    function automatic logic [SEC_W-1:0] sec_of(input logic hi_page, input logic [6:0] idx);
        logic [6:0] off;
        off = idx - REG_FIRST;
        sec_of = SEC_W'(int'(off) / REGS_PER_SEC + (hi_page ? SEC_PER_PAGE : 0));
    endfunction : sec_of

    function automatic logic [2:0] coef_of(input logic [6:0] idx);
        logic [6:0] off;
        off = idx - REG_FIRST;
        coef_of = 3'((int'(off) % REGS_PER_SEC) / BYTES_PER_COEF);
    endfunction : coef_of

    // byte 0 of a word is its top byte
    function automatic logic [1:0] lane_of(input logic [6:0] idx);
        logic [6:0] off;
        off = idx - REG_FIRST;
        lane_of = 2'(BYTES_PER_COEF - 1 - int'(off[1:0]));
    endfunction : lane_of

    // ------------------------------------------------------------------
    // coefficient write port
    // ------------------------------------------------------------------
    logic [COEF_W-1:0] coef_reg [NUM_SEC][COEFS_PER_SEC];

    wire page_lo_hit = (COEF_PAGE == PAGE_LO);
    wire page_hi_hit = (COEF_PAGE == PAGE_HI);
    wire index_hit = (COEF_INDEX >= REG_FIRST) && (COEF_INDEX <= REG_LAST);
    wire coef_write = COEF_WR_EN && (page_lo_hit || page_hi_hit) && index_hit;
    wire [SEC_W-1:0] wr_sec = sec_of(page_hi_hit, COEF_INDEX);
    wire [2:0] wr_coef = coef_of(COEF_INDEX);
    wire [1:0] wr_lane = lane_of(COEF_INDEX);

    // writes land immediately; a change during streaming is the host's hazard,
    // which is why the bank switch exists for live retuning
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            for (int s = 0; s < NUM_SEC; s++)
            begin
                for (int k = 0; k < COEFS_PER_SEC; k++)
                begin
                    coef_reg[s][k] <= (k == IDX_N0) ? COEF_UNITY : COEF_ZERO;
                end
            end
        end
        else if (CE && coef_write)
        begin
            coef_reg[wr_sec][wr_coef][wr_lane*8 +: 8] <= COEF_BYTE;
        end
    end

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    rbq_state_type state_reg;
    rbq_state_type state_next;
    logic [STAGE_W-1:0] stage_reg;
    logic [STAGE_W-1:0] stages_reg;
    logic [CH_W-1:0] ch_reg;
    logic two_ch_reg;
    logic bank_reg;
    logic [DATA_W-1:0] acc_reg;
    logic [DATA_W-1:0] x1_reg [NUM_SEC];
    logic [DATA_W-1:0] x2_reg [NUM_SEC];
    logic [DATA_W-1:0] y1_reg [NUM_SEC];
    logic [DATA_W-1:0] y2_reg [NUM_SEC];

    logic fifo_in_ready;

    wire idle = (state_reg == ST_IDLE);
    wire take = idle && IN_VALID;
    wire upper_ch = IN_CHANNEL[CH_W-1];
    // in two-channel use the upper channels hold the alternate banks, so their
    // own samples pass unfiltered rather than corrupt those banks' history
    wire take_bypass = (SECTION_ALLOCATION_SEL == ALLOC_BYPASS)
        || (TWO_CH_MODE && upper_ch);
    // field value is the per-channel section count: 1, 2 or 3
    wire [STAGE_W-1:0] take_stages = take_bypass ? ALLOC_BYPASS
        : SECTION_ALLOCATION_SEL;
    wire last_stage = (stage_reg == stages_reg - 1'b1);
    wire use_alt = two_ch_reg && bank_reg;
    wire [CH_W-1:0] ch_eff = use_alt ? ch_reg + ALT_BANK_OFFSET : ch_reg;
    // section = stage * 4 + channel, never above 11 as stage stops at 2
    wire [SEC_W-1:0] sec = SEC_W'(int'(stage_reg) * NUM_CH + int'(ch_eff));
    wire run_step = (state_reg == ST_RUN);
    wire push = (state_reg == ST_PUSH);

    // ------------------------------------------------------------------
    // one section, shared by every stage
    // ------------------------------------------------------------------
    logic signed [PROD_W-1:0] p_n0;
    logic signed [PROD_W-1:0] p_n1;
    logic signed [PROD_W-1:0] p_n2;
    logic signed [PROD_W-1:0] p_d1;
    logic signed [PROD_W-1:0] p_d2;
    logic signed [SUM_W-1:0] t_n0;
    logic signed [SUM_W-1:0] t_n1;
    logic signed [SUM_W-1:0] t_n2;
    logic signed [SUM_W-1:0] t_d1;
    logic signed [SUM_W-1:0] t_d2;
    logic signed [SUM_W-1:0] sum;
    logic signed [SUM_W-1:0] y_wide;
    logic [DATA_W-1:0] y_sat;

    assign p_n0 = $signed(coef_reg[sec][IDX_N0]) * $signed(acc_reg);
    assign p_n1 = $signed(coef_reg[sec][IDX_N1]) * $signed(x1_reg[sec]);
    assign p_n2 = $signed(coef_reg[sec][IDX_N2]) * $signed(x2_reg[sec]);
    assign p_d1 = $signed(coef_reg[sec][IDX_D1]) * $signed(y1_reg[sec]);
    assign p_d2 = $signed(coef_reg[sec][IDX_D2]) * $signed(y2_reg[sec]);
    // N1 and D1 carry a factor two; feedback adds since the denominator subtracts
    assign t_n0 = SUM_W'(p_n0);
    assign t_n1 = SUM_W'(p_n1) <<< 1;
    assign t_n2 = SUM_W'(p_n2);
    assign t_d1 = SUM_W'(p_d1) <<< 1;
    assign t_d2 = SUM_W'(p_d2);
    assign sum = t_n0 + t_n1 + t_n2 + t_d1 + t_d2;
    assign y_wide = sum >>> FRAC_SHIFT;

    wire y_ovf = (y_wide[SUM_W-1:DATA_W-1] != {(SUM_W-DATA_W+1){y_wide[DATA_W-1]}});
    // saturate rather than wrap: a wrapped feedback term turns into a limit cycle
    assign y_sat = y_ovf ? (y_wide[SUM_W-1] ? DATA_MIN : DATA_MAX)
        : y_wide[DATA_W-1:0];

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
            begin
                if (take)
                    state_next = (take_stages == ALLOC_BYPASS) ? ST_PUSH : ST_RUN;
            end
            ST_RUN:
            begin
                if (last_stage)
                    state_next = ST_PUSH;
            end
            ST_PUSH:
            begin
                if (fifo_in_ready)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_N)
        begin
            state_reg <= ST_IDLE;
            stage_reg <= '0;
            stages_reg <= ALLOC_TWO;
            ch_reg <= '0;
            two_ch_reg <= 1'b0;
            bank_reg <= 1'b0;
            acc_reg <= '0;
        end
        else if (CE)
        begin
            state_reg <= state_next;
            if (take)
            begin
                // bank and mode are caught per sample so a cascade never mixes banks
                stage_reg <= '0;
                stages_reg <= take_stages;
                ch_reg <= IN_CHANNEL;
                two_ch_reg <= TWO_CH_MODE;
                bank_reg <= BANK_SWITCH;
                acc_reg <= IN_DATA;
            end
            else if (run_step)
            begin
                stage_reg <= stage_reg + 1'b1;
                acc_reg <= y_sat;
            end
        end
    end

    // ------------------------------------------------------------------
    // per-section history
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_SEC; g++)
    begin : g_hist
        wire hit = run_step && (sec == SEC_W'(g));
        always_ff @(posedge CLK_SYS)
        begin
            if (!RST_N)
            begin
                x1_reg[g] <= '0;
                x2_reg[g] <= '0;
                y1_reg[g] <= '0;
                y2_reg[g] <= '0;
            end
            else if (CE && hit)
            begin
                x2_reg[g] <= x1_reg[g];
                x1_reg[g] <= acc_reg;
                y2_reg[g] <= y1_reg[g];
                y1_reg[g] <= y_sat;
            end
        end
    end

    // ------------------------------------------------------------------
    // output buffer
    // ------------------------------------------------------------------
    // a full fifo holds the sequencer in push, which drops IN_READY
    assign IN_READY = idle;
    assign ACTIVE_BANK = bank_reg;

    rbq_fifo #(
        .WIDTH(CH_W + DATA_W),
        .DEPTH(FIFO_WORDS)
    ) u_fifo (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .ce(CE),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data({ch_reg, acc_reg}),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data({OUT_CHANNEL, OUT_DATA})
    );

endmodule : rbq_filter_bank

// ---- tb/rbq_sink_model.sv ----
// ----------------------------------------
// downstream sink taking filtered words
// ----------------------------------------
module rbq_sink_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [rbq_pkg::DATA_W-1:0] out_data,
    output logic out_ready,
    output logic [7:0] rx_count
);
    timeunit 1ns;
    timeprecision 1ps;
    import rbq_pkg::*;
    logic [DATA_W-1:0] rx_data [0:255];
    // ready moves just after the edge, so a stall never races the sampling edge
    always @(posedge clk)
    begin
        if (!rst_n)
            out_ready <= 1'b0;
        else
            out_ready <= !stall;
    end
    always @(posedge clk)
    begin
        if (!rst_n)
            rx_count <= 8'h00;
        else if (out_valid && out_ready)
        begin
            rx_data[rx_count] <= out_data;
            rx_count <= rx_count + 8'h01;
        end
    end
endmodule : rbq_sink_model

// ---- tb/rbq_filter_bank_chk.sv ----
// ----------------------------------------
// port checker for the filter bank
// ----------------------------------------
module rbq_filter_bank_chk (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [1:0] SECTION_ALLOCATION_SEL,
    input wire logic TWO_CH_MODE,
    input wire logic BANK_SWITCH,
    input wire logic IN_VALID,
    input wire logic IN_READY,
    input wire logic [rbq_pkg::CH_W-1:0] IN_CHANNEL,
    input wire logic [rbq_pkg::DATA_W-1:0] IN_DATA,
    input wire logic OUT_VALID,
    input wire logic OUT_READY,
    input wire logic [rbq_pkg::DATA_W-1:0] OUT_DATA,
    input wire logic [rbq_pkg::CH_W-1:0] OUT_CHANNEL,
    input wire logic ACTIVE_BANK
);
    timeunit 1ns;
    timeprecision 1ps;
    import rbq_pkg::*;
    // latency is only fixed when the fifo is empty at accept
    wire acc = IN_VALID && IN_READY && CE;
    wire acc_nrm = acc && !OUT_VALID && !TWO_CH_MODE;
    wire [1:0] sel = SECTION_ALLOCATION_SEL;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_N);
    byp_latency_a: assert property (
        acc_nrm && sel == 2'h0 ##1 CE |-> !OUT_VALID ##1 (OUT_VALID
        && OUT_DATA == $past(IN_DATA, 2) && OUT_CHANNEL == $past(IN_CHANNEL, 2)))
        else $error("bypass word wrong");
    one_latency_a: assert property (
        acc_nrm && sel == 2'h1 ##1 CE [*2] |-> !OUT_VALID ##1 OUT_VALID)
        else $error("one-section latency wrong");
    two_latency_a: assert property (
        acc_nrm && sel == 2'h2 ##1 CE [*3] |-> !OUT_VALID ##1 OUT_VALID)
        else $error("two-section latency wrong");
    three_latency_a: assert property (
        acc_nrm && sel == 2'h3 ##1 CE [*4] |-> !OUT_VALID ##1 OUT_VALID)
        else $error("three-section latency wrong");
    busy_hold_a: assert property (
        acc && sel == 2'h3 && !TWO_CH_MODE |=> !IN_READY [*4])
        else $error("ready during three-section run");
    bank_latch_a: assert property (
        acc && TWO_CH_MODE && !IN_CHANNEL[1] |=> ACTIVE_BANK == $past(BANK_SWITCH))
        else $error("bank not latched at accept");
    bank_hold_a: assert property (
        !acc |=> $stable(ACTIVE_BANK))
        else $error("bank moved without a sample");
    split_bypass_a: assert property (
        acc && !OUT_VALID && TWO_CH_MODE && IN_CHANNEL[1] ##1 CE |-> !OUT_VALID ##1
        (OUT_VALID && OUT_DATA == $past(IN_DATA, 2)))
        else $error("two-channel bypass wrong");
    out_hold_a: assert property (
        OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
        else $error("output word lost while stalled");
endmodule : rbq_filter_bank_chk

bind rbq_filter_bank rbq_filter_bank_chk u_chk (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(CE), .SECTION_ALLOCATION_SEL(SECTION_ALLOCATION_SEL),
    .TWO_CH_MODE(TWO_CH_MODE), .BANK_SWITCH(BANK_SWITCH), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .IN_CHANNEL(IN_CHANNEL), .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .OUT_CHANNEL(OUT_CHANNEL),
    .ACTIVE_BANK(ACTIVE_BANK)
);

// ---- tb/rbq_filter_bank_bench.sv ----
module rbq_filter_bank_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rbq_pkg::*;
    // ----------------------------------------
    // stimulus, design and sink
    // ----------------------------------------
    logic clk_sys = 1'b0, rst_n = 1'b0, ce = 1'b1, two_ch = 1'b0, bank_sw = 1'b0;
    logic wr_en = 1'b0, in_valid = 1'b0, stall = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [7:0] page = 8'h00, byte_v = 8'h00, rx_count;
    logic [6:0] index = 7'h00;
    logic [CH_W-1:0] in_ch = 2'h0, out_ch;
    logic [DATA_W-1:0] in_data = 32'h0, out_data;
    logic in_ready, out_valid, out_ready, bank;
    int fail_count = 0, cmp_count = 0;
    rbq_filter_bank dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .CE(ce), .SECTION_ALLOCATION_SEL(sel),
        .TWO_CH_MODE(two_ch), .BANK_SWITCH(bank_sw), .COEF_WR_EN(wr_en), .COEF_PAGE(page),
        .COEF_INDEX(index), .COEF_BYTE(byte_v), .IN_VALID(in_valid), .IN_READY(in_ready),
        .IN_CHANNEL(in_ch), .IN_DATA(in_data), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_CHANNEL(out_ch), .OUT_DATA(out_data), .ACTIVE_BANK(bank)
    );
    rbq_sink_model sink (
        .clk(clk_sys), .rst_n(rst_n), .stall(stall), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready), .rx_count(rx_count)
    );
    initial
        forever #25 clk_sys = ~clk_sys;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : check
    task automatic expire(input int k);
        if (k >= 200)
        begin
            $display("[FAIL] wait expected event seen timeout");
            fail_count++;
            give_verdict();
        end
    endtask : expire
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_n = 1'b1;
    endtask : do_reset
    // msb byte goes to the lowest index of the word
    task automatic wr_coef(input logic [7:0] pg, input logic [6:0] idx, input logic [31:0] v);
        for (int b = 0; b < 4; b++)
        begin
            wr_en = 1'b1;
            page = pg;
            index = idx + 7'(b);
            byte_v = v[31 - 8 * b -: 8];
            @(negedge clk_sys);
        end
        wr_en = 1'b0;
        @(negedge clk_sys);
    endtask : wr_coef
    task automatic send(input logic [1:0] ch, input logic [31:0] x);
        int k;
        for (k = 0; k < 200 && in_ready !== 1'b1; k++)
            @(negedge clk_sys);
        expire(k);
        in_valid = 1'b1;
        in_ch = ch;
        in_data = x;
        @(negedge clk_sys);
        in_valid = 1'b0;
    endtask : send
    task automatic wait_rx(input logic [7:0] n);
        int k;
        for (k = 0; k < 200 && rx_count === n; k++)
            @(negedge clk_sys);
        expire(k);
    endtask : wait_rx
    task automatic xfer(input logic [1:0] ch, input logic [31:0] x, input logic [31:0] exp);
        logic [7:0] n;
        n = rx_count;
        send(ch, x);
        wait_rx(n);
        check("filtered sample", exp, sink.rx_data[n]);
    endtask : xfer
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_alloc();
        for (int s = 0; s < 4; s++)
        begin
            sel = 2'(s);
            for (int c = 0; c < 4; c++)
                xfer(2'(c), 32'h3e8, 32'h3e8 - 32'(s));
        end
        $display("test alloc done");
    endtask : t_alloc
    task automatic t_map();
        sel = 2'h2;
        wr_coef(8'h08, 7'h58, 32'h40000000);
        wr_coef(8'h09, 7'h6c, 32'h20000000);
        wr_coef(8'h07, 7'h08, 32'h40000000);
        wr_coef(8'h08, 7'h04, 32'h40000000);
        xfer(2'h0, 32'h3e8, 32'h1f3);
        xfer(2'h1, 32'h3e8, 32'h3e6);
        sel = 2'h3;
        xfer(2'h3, 32'h3e8, 32'hf9);
        xfer(2'h0, 32'h3e8, 32'h1f2);
        xfer(2'h2, 32'h3e8, 32'h3e5);
        $display("test map done");
    endtask : t_map
    task automatic t_fifo();
        logic [7:0] n;
        sel = 2'h0;
        stall = 1'b1;
        n = rx_count;
        for (int i = 0; i < 9; i++)
            send(2'(i), 32'(i + 1));
        repeat (4) @(negedge clk_sys);
        check("ready with fifo full", 32'h0, {31'h0, in_ready});
        check("valid with fifo full", 32'h1, {31'h0, out_valid});
        stall = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            wait_rx(n + 8'(i));
            check("fifo order", 32'(i + 1), sink.rx_data[n + 8'(i)]);
        end
        repeat (2) @(negedge clk_sys);
        check("valid after drain", 32'h0, {31'h0, out_valid});
        $display("test fifo done");
    endtask : t_fifo
    task automatic t_bank();
        do_reset();
        sel = 2'h1;
        wr_coef(8'h08, 7'h30, 32'h40000000);
        two_ch = 1'b1;
        bank_sw = 1'b1;
        xfer(2'h0, 32'h3e8, 32'h1f4);
        check("bank after switch", 32'h1, {31'h0, bank});
        xfer(2'h2, 32'h3e8, 32'h3e8);
        bank_sw = 1'b0;
        xfer(2'h0, 32'h3e8, 32'h3e7);
        check("bank after return", 32'h0, {31'h0, bank});
        two_ch = 1'b0;
        $display("test bank done");
    endtask : t_bank
    task automatic t_math();
        do_reset();
        sel = 2'h1;
        wr_coef(8'h08, 7'h08, 32'h40000000);
        wr_coef(8'h08, 7'h0c, 32'h20000000);
        wr_coef(8'h08, 7'h10, 32'h20000000);
        wr_coef(8'h08, 7'h14, 32'h20000000);
        wr_coef(8'h08, 7'h18, 32'h10000000);
        xfer(2'h0, 32'h3e8, 32'h1f4);
        xfer(2'h0, 32'h0, 32'h2ee);
        xfer(2'h0, 32'h0, 32'h2af);
        do_reset();
        xfer(2'h0, 32'h3e8, 32'h3e7);
        $display("test math done");
    endtask : t_math
    task automatic t_ce();
        logic [7:0] n;
        int k;
        n = rx_count;
        sel = 2'h1;
        send(2'h1, 32'h3e8);
        ce = 1'b0;
        repeat (5) @(negedge clk_sys);
        check("ready while frozen", 32'h0, {31'h0, in_ready});
        check("valid while frozen", 32'h0, {31'h0, out_valid});
        ce = 1'b1;
        for (k = 0; k < 200 && out_valid !== 1'b1; k++)
            @(negedge clk_sys);
        expire(k);
        check("channel after freeze", 32'h1, {30'h0, out_ch});
        wait_rx(n);
        check("sample after freeze", 32'h3e7, sink.rx_data[n]);
        $display("test ce done");
    endtask : t_ce
    initial
    begin
        do_reset();
        t_alloc();
        t_map();
        t_fifo();
        t_bank();
        t_math();
        t_ce();
        give_verdict();
    end
endmodule : rbq_filter_bank_bench
